// >>> logic/cpr_pkg.sv
package cpr_pkg;
  // Clock period, in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Lock settling time, in microseconds
  localparam int unsigned PLL_SETTLE_US = 100;
  localparam int unsigned PLL_SETTLE_CYC = (PLL_SETTLE_US * 1000) / CLK_PERIOD_NS;
  // Shortest external reset pulse that must be caught, in ns
  localparam int unsigned RST_PULSE_NS = 50;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Chip reset stretch after every source falls away
  localparam logic [3:0] RST_STRETCH = 4'h8;
  // PLL multiplier range
  localparam logic [5:0] PLL_MSEL_MIN = 6'h01;
  localparam logic [5:0] PLL_MSEL_MAX = 6'h20;
  // Watchdog oscillator setting reset value, in kHz steps
  localparam logic [11:0] WDOSC_FREQ_RST = 12'h05e;
  // Boot vector
  localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;
  // Number of peripherals, one clock gate each
  localparam int unsigned NUM_PERIPH = 16;

  typedef enum logic [1:0] {
    SRC_IRC   = 2'h0,
    SRC_SYSOSC = 2'h1,
    SRC_WDOSC = 2'h2,
    SRC_MAIN  = 2'h3
  } clk_src_t;

  typedef enum logic [1:0] {
    PDIV_2  = 2'h0,
    PDIV_4  = 2'h1,
    PDIV_8  = 2'h2,
    PDIV_16 = 2'h3
  } pll_pdiv_t;

  // Gray coded power states along the usual path
  typedef enum logic [2:0] {
    PM_RUN        = 3'b000,
    PM_SLEEP      = 3'b001,
    PM_DEEP_SLEEP = 3'b011,
    PM_POWER_DOWN = 3'b010,
    PM_DEEP_PD    = 3'b110
  } pm_state_t;

  typedef enum logic [1:0] {
    PLL_OFF    = 2'b00,
    PLL_SETTLE = 2'b01,
    PLL_LOCKED = 2'b11
  } pll_state_t;
endpackage

// >>> logic/cpr_if.sv
`timescale 1ns/10ps
interface cpr_if;
  import cpr_pkg::*;
  // Clock selection and PLL settings from the core side
  clk_src_t main_sel;
  clk_src_t clock_output_pin_sel;
  logic sys_pll_en;
  logic usb_pll_en;
  logic [5:0] pll_msel;
  pll_pdiv_t pll_pdiv;
  logic [NUM_PERIPH-1:0] periph_gate;
  logic [11:0] wdosc_freq;
  // Power control
  pm_state_t pm_req;
  logic pm_req_valid;
  logic dpd_lock;
  logic wd_keep;
  logic bod_keep;
  logic [1:0] bod_int_lvl;
  logic [1:0] bod_rst_lvl;
  logic bod_rst_en;
  // Device reports
  logic sys_pll_lock;
  logic usb_pll_lock;
  pm_state_t pm_state;
  logic core_clk_en;
  logic [NUM_PERIPH-1:0] periph_clk_en;
  logic bod_int;
  logic chip_rst_n;
  logic [31:0] boot_addr;
  clk_src_t main_active;

  modport device (
    input main_sel, clock_output_pin_sel, sys_pll_en, usb_pll_en, pll_msel, pll_pdiv, periph_gate, wdosc_freq,
    input pm_req, pm_req_valid, dpd_lock, wd_keep, bod_keep, bod_int_lvl, bod_rst_lvl, bod_rst_en,
    output sys_pll_lock, usb_pll_lock, pm_state, core_clk_en, periph_clk_en, bod_int, chip_rst_n,
    output boot_addr, main_active
  );
  modport host (
    output main_sel, clock_output_pin_sel, sys_pll_en, usb_pll_en, pll_msel, pll_pdiv, periph_gate, wdosc_freq,
    output pm_req, pm_req_valid, dpd_lock, wd_keep, bod_keep, bod_int_lvl, bod_rst_lvl, bod_rst_en,
    input sys_pll_lock, usb_pll_lock, pm_state, core_clk_en, periph_clk_en, bod_int, chip_rst_n,
    input boot_addr, main_active
  );
endinterface

// >>> logic/cpr_device.sv
`timescale 1ns/10ps
module cpr_device
  import cpr_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = PLL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Reset and wake sources
  input wire logic ext_rst_n_i,
  input wire logic wdt_rst_i,
  input wire logic por_i,
  input wire logic irq_i,
  input wire logic gpio_wake_i,
  input wire logic wdt_irq_i,
  input wire logic usb_act_i,
  input wire logic wake_pin_n_i,
  input wire logic [1:0] vdd_level_i,
  // Oscillator enables and clock output select
  output logic irc_on_o,
  output logic sysosc_on_o,
  output logic wdosc_on_o,
  output logic bod_on_o,
  output logic flash_on_o,
  output logic [1:0] clock_output_pin_sel_o,
  output logic [11:0] wdosc_freq_o,
  // Core side
  cpr_if.device cif
);
  // ==========================================================
  // Reset merge
  logic ext_rst_seen_q;
  logic [3:0] rst_cnt_q;
  logic any_rst;
  // A pulse of one cycle is already caught, well within the shortest pulse
  assign any_rst = !ext_rst_n_i || wdt_rst_i || por_i || (cif.bod_rst_en && vdd_level_i <= cif.bod_rst_lvl);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_cnt_q <= RST_STRETCH;
      ext_rst_seen_q <= 1'b1;
    end else if (any_rst) begin
      rst_cnt_q <= RST_STRETCH;
      ext_rst_seen_q <= 1'b1;
    end else if (rst_cnt_q != 4'h0) begin
      rst_cnt_q <= rst_cnt_q - 4'h1;
    end else begin
      ext_rst_seen_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.chip_rst_n <= 1'b0;
      cif.boot_addr <= BOOT_VECTOR;
    end else begin
      cif.chip_rst_n <= !ext_rst_seen_q;
      cif.boot_addr <= BOOT_VECTOR;
    end
  end
  logic rst_active;
  assign rst_active = ext_rst_seen_q;

  // ==========================================================
  // PLLs, identical system and USB
  function automatic logic settings_ok(input logic [5:0] m, input pll_pdiv_t p);
    // Only the four post-divide ratios exist; the smallest, 2, keeps the output duty cycle even
    settings_ok = (m >= PLL_MSEL_MIN) && (m <= PLL_MSEL_MAX) &&
                  (p inside {PDIV_2, PDIV_4, PDIV_8, PDIV_16});
  endfunction
  pll_state_t pll_q [2];
  logic [16:0] pll_cnt_q [2];
  logic [1:0] pll_en;
  assign pll_en = {cif.usb_pll_en, cif.sys_pll_en};
  // The loop divider and post-divider are analog; only legal settings arm lock
  for (genvar g = 0; g < 2; g++) begin : g_pll
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pll_q[g] <= PLL_OFF;
        pll_cnt_q[g] <= 17'h0;
      end else if (rst_active || !pll_en[g] || !settings_ok(cif.pll_msel, cif.pll_pdiv)) begin
        pll_q[g] <= PLL_OFF;
        pll_cnt_q[g] <= 17'h0;
      end else begin
        case (pll_q[g])
          PLL_OFF: begin
            pll_q[g] <= PLL_SETTLE;
            pll_cnt_q[g] <= 17'h0;
          end
          PLL_SETTLE: begin
            if (pll_cnt_q[g] >= 17'(SETTLE_CYC - 1)) begin
              pll_q[g] <= PLL_LOCKED;
            end else begin
              pll_cnt_q[g] <= pll_cnt_q[g] + 17'h1;
            end
          end
          PLL_LOCKED: pll_q[g] <= PLL_LOCKED;
          default: pll_q[g] <= PLL_OFF;
        endcase
      end
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.sys_pll_lock <= 1'b0;
      cif.usb_pll_lock <= 1'b0;
    end else begin
      cif.sys_pll_lock <= pll_q[0] == PLL_LOCKED;
      cif.usb_pll_lock <= pll_q[1] == PLL_LOCKED;
    end
  end

  // ==========================================================
  // Main clock select, switched only at a quiet point
  logic [1:0] sw_cnt_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.main_active <= SRC_IRC;
      sw_cnt_q <= 2'h0;
    end else if (rst_active || cif.pm_state == PM_DEEP_PD) begin
      cif.main_active <= SRC_IRC;
      sw_cnt_q <= 2'h0;
    end else if (cif.main_sel != cif.main_active) begin
      // Old source stays active for three cycles, while sw_cnt_q counts to 2, before the new one takes over
      sw_cnt_q <= sw_cnt_q + 2'h1;
      if (sw_cnt_q == 2'h2) begin
        cif.main_active <= cif.main_sel;
        sw_cnt_q <= 2'h0;
      end
    end else begin
      sw_cnt_q <= 2'h0;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clock_output_pin_sel_o <= SRC_IRC;
      wdosc_freq_o <= WDOSC_FREQ_RST;
    end else begin
      clock_output_pin_sel_o <= cif.clock_output_pin_sel;
      wdosc_freq_o <= cif.wdosc_freq;
    end
  end

  // ==========================================================
  // Power state machine
  logic wake_ev;
  assign wake_ev = gpio_wake_i || wdt_irq_i || usb_act_i || any_rst;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.pm_state <= PM_RUN;
    end else if (rst_active) begin
      cif.pm_state <= PM_RUN;
    end else begin
      case (cif.pm_state)
        PM_RUN: begin
          if (cif.pm_req_valid && !(cif.pm_req == PM_DEEP_PD && cif.dpd_lock)) begin
            cif.pm_state <= cif.pm_req;
          end
        end
        PM_SLEEP: if (irq_i || wake_ev) cif.pm_state <= PM_RUN;
        PM_DEEP_SLEEP, PM_POWER_DOWN: if (wake_ev) cif.pm_state <= PM_RUN;
        PM_DEEP_PD: if (!wake_pin_n_i) cif.pm_state <= PM_RUN;
        default: cif.pm_state <= PM_RUN;
      endcase
    end
  end

  // ==========================================================
  // Clock and power enables per state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.core_clk_en <= 1'b0;
      cif.periph_clk_en <= '0;
      irc_on_o <= 1'b1;
      sysosc_on_o <= 1'b0;
      wdosc_on_o <= 1'b0;
      bod_on_o <= 1'b1;
      flash_on_o <= 1'b1;
    end else begin
      cif.core_clk_en <= !rst_active && cif.pm_state == PM_RUN;
      cif.periph_clk_en <= (cif.pm_state inside {PM_RUN, PM_SLEEP}) ? cif.periph_gate : '0;
      irc_on_o <= rst_active || cif.pm_state inside {PM_RUN, PM_SLEEP, PM_DEEP_SLEEP};
      sysosc_on_o <= cif.pm_state inside {PM_RUN, PM_SLEEP};
      wdosc_on_o <= cif.pm_state inside {PM_RUN, PM_SLEEP} ||
                    (cif.wd_keep && cif.pm_state inside {PM_DEEP_SLEEP, PM_POWER_DOWN});
      bod_on_o <= cif.pm_state inside {PM_RUN, PM_SLEEP} ||
                  (cif.bod_keep && cif.pm_state inside {PM_DEEP_SLEEP, PM_POWER_DOWN});
      flash_on_o <= cif.pm_state inside {PM_RUN, PM_SLEEP, PM_DEEP_SLEEP};
    end
  end

  // ==========================================================
  // Brownout interrupt level
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.bod_int <= 1'b0;
    end else begin
      cif.bod_int <= bod_on_o && vdd_level_i <= cif.bod_int_lvl;
    end
  end
endmodule // cpr_device

// >>> logic/cpr_host.sv
`timescale 1ns/10ps
module cpr_host
  import cpr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // User requests
  input wire logic use_pll_i,
  input wire logic use_usb_i,
  input wire logic [5:0] msel_i,
  input wire logic [1:0] pdiv_i,
  input wire logic [1:0] clock_output_pin_sel_i,
  input wire logic [NUM_PERIPH-1:0] gate_i,
  input wire logic [11:0] wdosc_freq_i,
  input wire logic pm_go_i,
  input wire logic [2:0] pm_req_i,
  input wire logic [5:0] pm_opt_i,
  input wire logic bod_rst_en_i,
  // Status
  output logic pll_ready_o,
  output logic bod_flag_o,
  // Core side
  cpr_if.host cif
);
  // ==========================================================
  // Settings; PLL reference must be the system oscillator for USB
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.sys_pll_en <= 1'b0;
      cif.usb_pll_en <= 1'b0;
      cif.pll_msel <= PLL_MSEL_MIN;
      cif.pll_pdiv <= PDIV_2;
      cif.clock_output_pin_sel <= SRC_IRC;
      cif.periph_gate <= '1;
      cif.wdosc_freq <= WDOSC_FREQ_RST;
      cif.dpd_lock <= 1'b0;
      cif.wd_keep <= 1'b0;
      cif.bod_keep <= 1'b0;
      cif.bod_int_lvl <= 2'h0;
      cif.bod_rst_lvl <= 2'h0;
      cif.bod_rst_en <= 1'b0;
    end else begin
      cif.sys_pll_en <= use_pll_i;
      cif.usb_pll_en <= use_usb_i;
      cif.pll_msel <= msel_i;
      cif.pll_pdiv <= pll_pdiv_t'(pdiv_i);
      cif.clock_output_pin_sel <= clk_src_t'(clock_output_pin_sel_i);
      cif.periph_gate <= gate_i;
      cif.wdosc_freq <= wdosc_freq_i;
      cif.dpd_lock <= pm_opt_i[0];
      cif.wd_keep <= pm_opt_i[1];
      cif.bod_keep <= pm_opt_i[2];
      cif.bod_int_lvl <= pm_opt_i[4:3];
      cif.bod_rst_lvl <= {1'b0, pm_opt_i[5]};
      cif.bod_rst_en <= bod_rst_en_i;
    end
  end
  // ==========================================================
  // Main select: move to SRC_MAIN only after system PLL lock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.main_sel <= SRC_IRC;
      pll_ready_o <= 1'b0;
    end else begin
      pll_ready_o <= cif.sys_pll_lock;
      cif.main_sel <= (use_pll_i && cif.sys_pll_lock) ? SRC_MAIN : SRC_IRC;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cif.pm_req <= PM_RUN;
      cif.pm_req_valid <= 1'b0;
      bod_flag_o <= 1'b0;
    end else begin
      cif.pm_req <= pm_state_t'(pm_req_i);
      cif.pm_req_valid <= pm_go_i;
      bod_flag_o <= cif.bod_int;
    end
  end
endmodule // cpr_host

// >>> sim/cpr_assertions.sv
`timescale 1ns/10ps
module cpr_assertions
  import cpr_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Host requests
  input clk_src_t main_sel,
  input logic sys_pll_en,
  input logic [5:0] pll_msel,
  input pm_state_t pm_req,
  input logic pm_req_valid,
  input logic dpd_lock,
  // Device reports
  input logic sys_pll_lock,
  input logic usb_pll_lock,
  input pm_state_t pm_state,
  input logic core_clk_en,
  input logic [NUM_PERIPH-1:0] periph_clk_en,
  input logic chip_rst_n,
  input logic [31:0] boot_addr,
  input clk_src_t main_active
);
  // Host may take one edge to pass the enable on
  localparam int LOCK_MAX = SETTLE_CYC + 3;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ================
  // Reset behaviour
  property p_boot; $rose(chip_rst_n) |-> boot_addr == 32'h0; endproperty
  a_boot: assert property (p_boot) else $error("boot address not zero");
  property p_irc; !chip_rst_n |-> main_active == SRC_IRC; endproperty
  a_irc: assert property (p_irc) else $error("not on internal rc in reset");
  property p_pll_rst; !chip_rst_n && !$past(chip_rst_n) |-> !sys_pll_lock && !usb_pll_lock; endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("pll locked in reset");
  // ================
  // PLL
  property p_lock;
    $rose(sys_pll_en) && chip_rst_n && pll_msel inside {[PLL_MSEL_MIN:PLL_MSEL_MAX]} |-> ##[1:LOCK_MAX] sys_pll_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("pll lock late");
  property p_refuse;
    sys_pll_en && !(pll_msel inside {[PLL_MSEL_MIN:PLL_MSEL_MAX]}) && !sys_pll_lock |=> !sys_pll_lock;
  endproperty
  a_refuse: assert property (p_refuse) else $error("pll locked on bad multiplier");
  // ================
  // Power and clock switching
  property p_sleep; pm_state == PM_SLEEP && $past(pm_state) == PM_SLEEP |-> !core_clk_en && $stable(periph_clk_en); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_deep;
    pm_state inside {PM_DEEP_SLEEP, PM_POWER_DOWN} && $past(pm_state) == pm_state |-> !core_clk_en && periph_clk_en == '0;
  endproperty
  a_deep: assert property (p_deep) else $error("deep state clocks running");
  property p_dpd; pm_req_valid && pm_req == PM_DEEP_PD && dpd_lock |=> (pm_state != PM_DEEP_PD) [*2]; endproperty
  a_dpd: assert property (p_dpd) else $error("locked deep power-down entered");
  property p_gap; $changed(main_active) |=> $stable(main_active); endproperty
  a_gap: assert property (p_gap) else $error("clock switch without gap");
  property p_follow; $changed(main_sel) && chip_rst_n |-> ##[1:4] main_active == main_sel; endproperty
  a_follow: assert property (p_follow) else $error("main clock did not follow");
endmodule // cpr_assertions

// >>> sim/clock_power_reset_control_bench.sv
`timescale 1ns/10ps
module clock_power_reset_control_bench;
  import cpr_pkg::*;
  // ================
  // Stimulus and plumbing
  logic clk_i, rstn_i, ext_rst_n, wdt_rst, por, irq, gpio_w, wdt_irq, usb_act, wake_n, use_pll, use_usb, pm_go, bod_en;
  logic [1:0] vdd, pdiv, cksel, cko;
  logic [5:0] msel, opt;
  logic [15:0] gate;
  logic [11:0] wdf, watchdog_osc;
  logic [2:0] pm_rq;
  logic irc_on, sysosc_on, wdosc_on, bod_on, flash_on, ready, bflag;
  logic [7:0] probe;
  int n_mismatch, comparisons;
  cpr_if cif();
  cpr_device #(.SETTLE_CYC(20)) i_cpr_device(.clk_i(clk_i), .rstn_i(rstn_i), .ext_rst_n_i(ext_rst_n),
    .wdt_rst_i(wdt_rst), .por_i(por), .irq_i(irq), .gpio_wake_i(gpio_w), .wdt_irq_i(wdt_irq), .usb_act_i(usb_act),
    .wake_pin_n_i(wake_n), .vdd_level_i(vdd), .irc_on_o(irc_on), .sysosc_on_o(sysosc_on), .wdosc_on_o(wdosc_on),
    .bod_on_o(bod_on), .flash_on_o(flash_on), .clock_output_pin_sel_o(cko), .wdosc_freq_o(watchdog_osc), .cif(cif));
  cpr_host i_cpr_host(.clk_i(clk_i), .rstn_i(rstn_i), .use_pll_i(use_pll), .use_usb_i(use_usb), .msel_i(msel),
    .pdiv_i(pdiv), .clock_output_pin_sel_i(cksel), .gate_i(gate), .wdosc_freq_i(wdf), .pm_go_i(pm_go), .pm_req_i(pm_rq),
    .pm_opt_i(opt), .bod_rst_en_i(bod_en), .pll_ready_o(ready), .bod_flag_o(bflag), .cif(cif));
  cpr_assertions #(.SETTLE_CYC(20)) i_cpr_assertions(.clk_i(clk_i), .rstn_i(rstn_i), .main_sel(cif.main_sel),
    .sys_pll_en(cif.sys_pll_en), .pll_msel(cif.pll_msel), .pm_req(cif.pm_req), .pm_req_valid(cif.pm_req_valid),
    .dpd_lock(cif.dpd_lock), .sys_pll_lock(cif.sys_pll_lock), .usb_pll_lock(cif.usb_pll_lock),
    .pm_state(cif.pm_state), .core_clk_en(cif.core_clk_en), .periph_clk_en(cif.periph_clk_en),
    .chip_rst_n(cif.chip_rst_n), .boot_addr(cif.boot_addr), .main_active(cif.main_active));
  assign probe = {cif.sys_pll_lock, cif.usb_pll_lock, cif.chip_rst_n, cif.core_clk_en, 1'h0, cif.pm_state};
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // ================
  // Shared tasks
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task results();
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait on the probe bits; running out ends the run
  task wt(input logic [7:0] m, input logic [7:0] v, input int lim);
    int k;
    for (k = 0; k < lim && (probe & m) !== v; k++) step(1);
    chk(probe & m, v);
    if ((probe & m) !== v) results();
  endtask
  task req(input pm_state_t s, input logic [5:0] o);
    pm_rq = s;
    opt = o;
    pm_go = 1'h1;
    step(1);
    pm_go = 1'h0;
  endtask
  // ================
  // Scenarios
  task automatic t_pll();
    logic [5:0] tab [4] = '{6'h01, 6'h20, 6'h00, 6'h21};
    for (int i = 0; i < 4; i++) begin
      msel = tab[i];
      pdiv = i[1:0];
      step(1);
      {use_pll, use_usb} = 2'h3;
      if (i < 2) begin
        wt(8'hc0, 8'hc0, 26);
        step(2);
        chk(ready, 1'h1);
        chk(cif.pll_pdiv, i[1:0]);
        // The host moves over after lock; the switch then waits out its quiet gap
        step(3);
        chk(cif.main_active, SRC_MAIN);
      end else begin
        step(30);
        chk(probe[7:6], 2'h0);
      end
      {use_pll, use_usb} = 2'h0;
      wt(8'hc0, 8'h00, 5);
    end
  endtask
  task automatic t_clk();
    logic [15:0] a;
    for (int i = 0; i < 4; i++) begin
      cksel = i[1:0];
      wdf = 12'h100 + i[11:0];
      step(4);
      chk(cko, i[1:0]);
      chk(watchdog_osc, 12'h100 + i[11:0]);
    end
    gate = 16'h0000;
    step(4);
    a = cif.periph_clk_en;
    gate = 16'ha5c3;
    step(4);
    chk(cif.periph_clk_en ^ a, 16'ha5c3);
  endtask
  // Enter a power state, check what stays on, then wake by source w
  task t_pm(input pm_state_t s, input logic [5:0] o, input int w);
    req(s, o);
    wt(8'h07, {5'h0, s}, 6);
    step(2);
    chk(cif.core_clk_en, 1'h0);
    if (s != PM_SLEEP) begin
      chk(cif.periph_clk_en, 16'h0);
      chk({sysosc_on, wdosc_on, bod_on, irc_on, flash_on}, {1'h0, o[1], o[2], s == PM_DEEP_SLEEP,
        s == PM_DEEP_SLEEP});
    end
    {wake_n, usb_act, wdt_irq, gpio_w, irq} = 5'h10 ^ (5'h01 << w);
    step(1);
    {wake_n, usb_act, wdt_irq, gpio_w, irq} = 5'h10;
    wt(8'h37, 8'h30, 30);
    chk(cif.main_active, SRC_IRC);
  endtask
  task t_rst();
    // Brownout reset is armed a cycle ahead, since the host passes its enable on one edge late
    bod_en = 1'h1;
    step(1);
    for (int j = 0; j < 4; j++) begin
      {por, wdt_rst, ext_rst_n} = 3'h1 ^ (3'h1 << j);
      vdd = (j == 3) ? 2'h0 : 2'h3;
      step(1);
      {por, wdt_rst, ext_rst_n} = 3'h1;
      vdd = 2'h3;
      wt(8'h20, 8'h00, 4);
      wt(8'h20, 8'h20, 20);
      chk({cif.main_active, cif.boot_addr}, 34'h0);
    end
  endtask
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    rstn_i = 1'h0;
    {ext_rst_n, wdt_rst, por, irq, gpio_w, wdt_irq, usb_act, wake_n} = 8'h81;
    {use_pll, use_usb, pm_go, bod_en} = 4'h0;
    {vdd, pdiv, cksel, pm_rq} = 9'h180;
    msel = 6'h01;
    opt = 6'h00;
    gate = 16'hffff;
    wdf = 12'h05e;
    repeat (10) @(posedge clk_i);
    #1 rstn_i = 1'h1;
    wt(8'h20, 8'h20, 20);
    chk({cif.boot_addr, cif.main_active, probe[7:6], irc_on, sysosc_on, wdosc_on, bod_on, flash_on}, 41'h1f);
    t_pll();
    t_clk();
    t_pm(PM_SLEEP, 6'h00, 0);
    for (int w = 1; w < 4; w++) begin
      t_pm(PM_DEEP_SLEEP, 6'h04, w);
      t_pm(PM_POWER_DOWN, 6'h02, w);
    end
    t_pm(PM_DEEP_PD, 6'h00, 4);
    req(PM_DEEP_PD, 6'h01);
    step(4);
    chk(cif.pm_state, PM_RUN);
    opt = 6'h08;
    vdd = 2'h2;
    step(4);
    chk(bflag, 1'h0);
    vdd = 2'h1;
    step(4);
    chk(bflag, 1'h1);
    vdd = 2'h3;
    step(2);
    t_rst();
    results();
  end
endmodule // clock_power_reset_control_bench
